// *** testbench/pfs_ctrl_model.sv ***
// Controller and PWM modulator model
`timescale 1ns/100ps
module pfs_ctrl_model #(parameter int HOLD_CYC = 8) (
  input wire logic mclk_in,
  input wire logic [3:0] run_in, // Channels with PWM running
  input wire logic rst_req_in, // Bench wants reset released
  input wire logic [2:0] half_in, // PWM half period in cycles
  input wire logic fault_oe_in,
  input wire logic warn_oe_in,
  output logic [3:0] pwm_out,
  output logic reset_n_out,
  output logic fault_n_out,
  output logic warn_n_out
);
  int cnt = 0; // PWM phase
  int gap = 0; // Cycles since fault last seen low
  initial pwm_out = 4'h0;
  initial reset_n_out = 1'b0;
  // Pull-ups on the open-drain report lines
  assign fault_n_out = !fault_oe_in;
  assign warn_n_out = !warn_oe_in;
  // Stopped channels freeze, as a stalled modulator would
  always @(posedge mclk_in) begin
    cnt <= (cnt + 1 >= int'(half_in)) ? 0 : cnt + 1;
    if (cnt == 0) begin
      pwm_out <= pwm_out ^ run_in;
    end
    gap <= fault_n_out ? gap + 1 : 0;
    // Reset rises only well after the last fault report
    reset_n_out <= rst_req_in && (reset_n_out || gap >= HOLD_CYC);
  end
endmodule : pfs_ctrl_model

// *** testbench/pfs_supervisor_assertions.sv ***
// Port checks for the fault supervisor
`timescale 1ns/100ps
module pfs_sva import pfs_pkg::*; (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic por_in,
  input wire logic reset_n_in,
  input wire pfs_mode_t mode_in,
  input wire logic latched_oc_mode_in,
  input wire pfs_chan_det_t chan_det_in,
  input wire pfs_glob_det_t glob_det_in,
  input wire logic [PFS_NCH-1:0] hs_on_out,
  input wire logic [PFS_NCH-1:0] hiz_out,
  input wire logic fault_oe_out,
  input wire logic fault_o_out,
  input wire logic warn_oe_out,
  input wire logic warn_o_out
);
  logic run; // Clocked, powered and out of reset
  logic uv; // Any supply low
  assign run = ce_in && !por_in && reset_n_in;
  assign uv = |glob_det_in[3:0];
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  // Windows long enough to cover sync flops and output register
  sequence s_trip;
    (run && glob_det_in.thermal_trip) [*5];
  endsequence
  sequence s_uv;
    (run && uv) [*5];
  endsequence
  property p_od;
    !fault_o_out && !warn_o_out;
  endproperty
  property p_trip;
    s_trip |-> hiz_out == 4'hf && fault_oe_out && warn_oe_out;
  endproperty
  property p_uv;
    s_uv |-> hiz_out == 4'hf && fault_oe_out;
  endproperty
  property p_rst;
    (ce_in && !por_in && !reset_n_in && mode_in == PFS_SINGLE_ENDED) [*8]
      |-> !fault_oe_out && hiz_out == 4'hf;
  endproperty
  property p_warn;
    (ce_in && glob_det_in.warn_temp) [*4] |-> warn_oe_out;
  endproperty
  property p_busy;
    $fell(rst_in) && ce_in && !por_in && mode_in != PFS_SINGLE_ENDED |-> ##5 fault_oe_out;
  endproperty
  property p_ocl;
    (run && latched_oc_mode_in && mode_in == PFS_BRIDGED
      && chan_det_in.overcurrent_trip[0]) [*6] |-> hiz_out[1:0] == 2'h3 && fault_oe_out;
  endproperty
  property p_boot;
    (ce_in && chan_det_in.bootstrap_cap_low[2]) [*4] |-> !hs_on_out[2];
  endproperty
  a_od: assert property (p_od) else $error("report data not low");
  a_trip: assert property (p_trip) else $error("trip not shut");
  a_uv: assert property (p_uv) else $error("low supply not shut");
  a_rst: assert property (p_rst) else $error("reset pin not obeyed");
  a_warn: assert property (p_warn) else $error("warning missing");
  a_busy: assert property (p_busy) else $error("check not reported");
  a_ocl: assert property (p_ocl) else $error("overcurrent not latched");
  a_boot: assert property (p_boot) else $error("high side on");
endmodule : pfs_sva
bind pfs_supervisor pfs_sva pfs_sva_i (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in),
  .por_in(por_in), .reset_n_in(reset_n_in), .mode_in(mode_in),
  .latched_oc_mode_in(latched_oc_mode_in), .chan_det_in(chan_det_in),
  .glob_det_in(glob_det_in), .hs_on_out(hs_on_out), .hiz_out(hiz_out),
  .fault_oe_out(fault_oe_out), .fault_o_out(fault_o_out), .warn_oe_out(warn_oe_out),
  .warn_o_out(warn_o_out));

// *** testbench/tb.sv ***
// Self-checking bench for the fault supervisor
`timescale 1ns/100ps
module tb;
  import pfs_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic por_in = 1'b0;
  logic loc = 1'b1; // Latched overcurrent mode
  logic rst_req = 1'b1;
  logic [3:0] run = 4'hf;
  logic [2:0] half = 3'h2;
  logic [31:0] rnd = 32'hbfb4eeef;
  pfs_mode_t mode_in = PFS_BRIDGED;
  pfs_chan_det_t cd = '0;
  pfs_glob_det_t gd = '0;
  logic reset_n, fault_n, warn_n, foe, fo, woe, wo;
  logic [3:0] pwm, hs, ls, hiz;
  logic [5:0] st; // Hi-Z mask, fault, warning
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  assign st = {hiz, foe, woe};
  always #2.5 mclk_in = ~mclk_in;
  pfs_supervisor #(.CHECK_STEP_CYC(20), .CBC_LIMIT_CYC(50), .PWM_LOSS_CYC(16))
    pfs_supervisor_i (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in), .por_in(por_in),
    .reset_n_in(reset_n), .mode_in(mode_in), .latched_oc_mode_in(loc), .pwm_in(pwm),
    .chan_det_in(cd), .glob_det_in(gd), .hs_on_out(hs), .ls_on_out(ls), .hiz_out(hiz),
    .fault_oe_out(foe), .fault_o_out(fo), .warn_oe_out(woe), .warn_o_out(wo));
  pfs_ctrl_model pfs_ctrl_model_i (.mclk_in(mclk_in), .run_in(run), .rst_req_in(rst_req),
    .half_in(half), .fault_oe_in(foe), .warn_oe_in(woe), .pwm_out(pwm),
    .reset_n_out(reset_n), .fault_n_out(fault_n), .warn_n_out(warn_n));
  // Bridges stopped by a channel fault
  function automatic logic [3:0] pair(input int ch, input pfs_mode_t m);
    return (m == PFS_PAR_BRIDGED) ? 4'hf : ((ch < 2) ? 4'h3 : 4'hc);
  endfunction : pair
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic w(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : w
  task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic start(input pfs_mode_t m);
    rst_in = 1'b1;
    mode_in = m;
    w(10);
    rst_in = 1'b0;
  endtask : start
  // Reset pulse; the model delays the rise after a fault
  task automatic clr();
    rst_req = 1'b0;
    w(4);
    rst_req = 1'b1;
    w(24);
  endtask : clr
  task automatic print_verdict();
    if (error_cnt == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  // A hung run counts as a mismatch
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    cd.short_gnd = 4'h2;
    start(PFS_BRIDGED);
    w(10);
    rst_req = 1'b0;
    w(6);
    chk(st, 6'h3e);
    rst_req = 1'b1;
    w(60);
    chk(st, 6'h3e);
    cd.short_gnd = 4'h0;
    w(90);
    chk(st, 6'h00);
    cd.short_sup = 4'h1;
    w(20);
    chk(st, 6'h00);
    cd.short_sup = 4'h0;
    gd.thermal_trip = 1'b1;
    w(6);
    chk(st, 6'h3f);
    chk({2'h0, hs | ls}, 6'h00);
    gd.thermal_trip = 1'b0;
    w(10);
    chk(st, 6'h3f);
    rst_req = 1'b0;
    w(6);
    chk(st, 6'h3d);
    rst_req = 1'b1;
    w(15);
    chk(st, 6'h00);
    gd.warn_temp = 1'b1;
    cd.bootstrap_cap_low = 4'h4;
    w(6);
    chk(st, 6'h01);
    chk({2'h0, hs & 4'h4}, 6'h00);
    chk({4'h0, fault_n, warn_n}, 6'h02);
    gd = '0;
    cd = '0;
    w(6);
    chk(st, 6'h00);
    for (int i = 0; i < 4; i++) begin
      gd[i] = 1'b1;
      w(6);
      chk(st, 6'h3e);
      gd[i] = 1'b0;
      w(10);
      chk(st, 6'h00);
    end
    por_in = 1'b1;
    w(6);
    chk(st, 6'h3e);
    por_in = 1'b0;
    w(90);
    chk(st, 6'h00);
    for (int ch = 0; ch < 5; ch++) begin
      if (ch == 4) begin
        rnd = xs(rnd);
        start(PFS_PAR_BRIDGED);
        w(90);
      end
      cd.overcurrent_trip[ch % 4 + ((ch == 4) ? int'(rnd[1:0]) : 0)] = 1'b1;
      w(6);
      chk(st, {pair(ch, mode_in), 2'h2});
      cd = '0;
      w(4);
      chk(st, {pair(ch, mode_in), 2'h2});
      clr();
      chk(st, 6'h00);
    end
    loc = 1'b0;
    half = {1'b0, rnd[3:2]} + 3'h1;
    cd.overcurrent_trip[1] = 1'b1;
    w(10);
    // Limiting is unreported and keeps every bridge switching
    chk(st, 6'h00);
    chk({5'h0, hs[1] ^ ls[1]}, 6'h01);
    w(60);
    chk(st, 6'h3e);
    cd = '0;
    clr();
    run = 4'h7;
    w(30);
    // Still parallel-bridged here, so one lost channel stops all four
    chk(st, 6'h3c);
    run = 4'h0;
    w(30);
    chk(st, 6'h3c);
    run = 4'hf;
    w(30);
    chk(st, 6'h00);
    rst_req = 1'b0;
    cd.short_gnd = 4'hf;
    start(PFS_SINGLE_ENDED);
    w(12);
    chk(st, 6'h3c);
    rst_req = 1'b1;
    w(24);
    chk(st, 6'h00);
    print_verdict();
  end
endmodule : tb

// *** verilog/pfs_pkg.sv ***
// Constants and carrier types for the power stage fault supervisor
package pfs_pkg;
  localparam int unsigned PFS_CLK_MHZ = 200;
  // Per-cycle limiting persistence before overload latch, in microseconds
  localparam int unsigned PFS_CBC_LIMIT_US = 2600;
  localparam int unsigned PFS_CBC_LIMIT_CYC = PFS_CBC_LIMIT_US * PFS_CLK_MHZ;
  // Default short check step length, in microseconds (7.5 ms per uF at 1 uF)
  localparam int unsigned PFS_CHECK_STEP_US = 7500;
  localparam int unsigned PFS_CHECK_STEP_CYC = PFS_CHECK_STEP_US * PFS_CLK_MHZ;
  // Default missing-PWM window, in microseconds
  localparam int unsigned PFS_PWM_LOSS_US = 50;
  localparam int unsigned PFS_PWM_LOSS_CYC = PFS_PWM_LOSS_US * PFS_CLK_MHZ;
  localparam int unsigned PFS_NCH = 4;
  // Output configuration codes
  typedef enum logic [1:0] {
    PFS_BRIDGED = 2'h0,
    PFS_PAR_BRIDGED = 2'h1,
    PFS_SINGLE_ENDED = 2'h2
  } pfs_mode_t;
  // Short check sequence states, one-hot
  typedef enum logic [3:0] {
    PFS_CHK_GND = 4'h1,
    PFS_CHK_SUP = 4'h2,
    PFS_CHK_HOLD = 4'h4,
    PFS_CHK_DONE = 4'h8
  } pfs_chk_t;
  // Per-channel detector bundle
  typedef struct packed {
    logic [PFS_NCH-1:0] overcurrent_trip;
    logic [PFS_NCH-1:0] bootstrap_cap_low;
    logic [PFS_NCH-1:0] short_gnd;
    logic [PFS_NCH-1:0] short_sup;
  } pfs_chan_det_t;
  // Global detector bundle
  typedef struct packed {
    logic warn_temp;
    logic thermal_trip;
    logic main_low;
    logic gate_low;
    logic stage_low;
    logic analog_low;
  } pfs_glob_det_t;
endpackage : pfs_pkg

// *** verilog/pfs_supervisor.sv ***
// Fault supervisor top: short check, thermal, supply, overcurrent, PWM loss
`timescale 1ns/100ps
module pfs_supervisor import pfs_pkg::*; #(
  parameter int unsigned CHECK_STEP_CYC = PFS_CHECK_STEP_CYC,
  parameter int unsigned CBC_LIMIT_CYC = PFS_CBC_LIMIT_CYC,
  parameter int unsigned PWM_LOSS_CYC = PFS_PWM_LOSS_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic por_in,
  input wire logic reset_n_in,
  input wire pfs_mode_t mode_in,
  input wire logic latched_oc_mode_in,
  input wire logic [PFS_NCH-1:0] pwm_in,
  input wire pfs_chan_det_t chan_det_in,
  input wire pfs_glob_det_t glob_det_in,
  output logic [PFS_NCH-1:0] hs_on_out,
  output logic [PFS_NCH-1:0] ls_on_out,
  output logic [PFS_NCH-1:0] hiz_out,
  output logic fault_oe_out,
  output logic fault_o_out,
  output logic warn_oe_out,
  output logic warn_o_out
);
  initial begin
    if (CHECK_STEP_CYC < 1 || CBC_LIMIT_CYC < 1 || PWM_LOSS_CYC < 2) begin
      $error("pfs_supervisor: counts out of range");
    end
  end

  localparam int CW = 32;
  localparam int DW = $bits(pfs_chan_det_t) + $bits(pfs_glob_det_t) + PFS_NCH + 2;

  // Two-stage synchroniser for every asynchronous input
  logic [DW-1:0] sync1_reg;
  logic [DW-1:0] sync2_reg;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (ce_in) begin
      sync1_reg <= {chan_det_in, glob_det_in, pwm_in, reset_n_in, por_in};
      sync2_reg <= sync1_reg;
    end
  end

  // Unpacked views of the synchronised inputs
  pfs_chan_det_t cd;
  pfs_glob_det_t gd;
  logic [PFS_NCH-1:0] pwm_s;
  logic rstn_s;
  logic por_s;
  assign {cd, gd, pwm_s, rstn_s, por_s} = sync2_reg;

  // Reset pin edge tracking; a rising edge clears latched faults
  logic rstn_d_reg;
  logic rstn_rise;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rstn_d_reg <= 1'b0;
    end else if (ce_in) begin
      rstn_d_reg <= rstn_s;
    end
  end
  assign rstn_rise = rstn_s && !rstn_d_reg;

  // Short check sequencer; power-on clear or rst_in restarts it, never the reset pin
  pfs_chk_t chk_reg;
  logic [CW-1:0] chk_cnt_reg;
  logic chk_busy;
  logic chk_short;
  assign chk_busy = (chk_reg != PFS_CHK_DONE);
  assign chk_short = (chk_reg == PFS_CHK_HOLD);
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      chk_reg <= PFS_CHK_GND;
      chk_cnt_reg <= '0;
    end else if (ce_in) begin
      if (por_s) begin
        chk_reg <= PFS_CHK_GND;
        chk_cnt_reg <= '0;
      end else begin
        unique case (chk_reg)
          PFS_CHK_GND: begin
            if (mode_in == PFS_SINGLE_ENDED) begin
              chk_reg <= PFS_CHK_DONE;
            end else if (|cd.short_gnd) begin
              chk_reg <= PFS_CHK_HOLD;
            end else if (chk_cnt_reg == CW'(CHECK_STEP_CYC - 1)) begin
              chk_reg <= PFS_CHK_SUP;
              chk_cnt_reg <= '0;
            end else begin
              chk_cnt_reg <= chk_cnt_reg + 1'b1;
            end
          end
          PFS_CHK_SUP: begin
            if (|cd.short_sup) begin
              chk_reg <= PFS_CHK_HOLD;
            end else if (chk_cnt_reg == CW'(CHECK_STEP_CYC - 1)) begin
              chk_reg <= PFS_CHK_DONE;
              chk_cnt_reg <= '0;
            end else begin
              chk_cnt_reg <= chk_cnt_reg + 1'b1;
            end
          end
          PFS_CHK_HOLD: begin
            // Retest from the first step once the short has cleared
            if (!(|cd.short_gnd) && !(|cd.short_sup)) begin
              chk_reg <= PFS_CHK_GND;
              chk_cnt_reg <= '0;
            end
          end
          PFS_CHK_DONE: begin
            chk_reg <= PFS_CHK_DONE;
          end
        endcase
      end
    end
  end

  // Supply undervoltage is global and self-clearing
  logic uv_glob;
  assign uv_glob = gd.main_low | gd.gate_low | gd.stage_low | gd.analog_low | por_s;

  // Thermal trip latch; cleared by a reset rising edge, set wins over clear
  logic therm_lat_reg;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      therm_lat_reg <= 1'b0;
    end else if (ce_in) begin
      if (gd.thermal_trip) begin
        therm_lat_reg <= 1'b1;
      end else if (rstn_rise || por_s) begin
        therm_lat_reg <= 1'b0;
      end
    end
  end

  // Half-clock-rate toggle used for per-cycle flipping
  logic flip_reg;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      flip_reg <= 1'b0;
    end else if (ce_in) begin
      flip_reg <= ~flip_reg;
    end
  end

  // Per-channel overcurrent, overload and PWM loss logic
  logic [PFS_NCH-1:0] ovl_lat_reg;
  logic [PFS_NCH-1:0] pwm_lost_reg;
  logic [PFS_NCH-1:0] ch_fault;
  logic [CW-1:0] cbc_cnt_reg [PFS_NCH];
  logic [CW-1:0] idle_cnt_reg [PFS_NCH];
  logic [PFS_NCH-1:0] pwm_d_reg;
  logic [PFS_NCH-1:0] oc_limiting;

  for (genvar i = 0; i < PFS_NCH; i++) begin : g_ch
    // Overload guard: latched mode trips at once, per-cycle mode after persistence
    always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
        ovl_lat_reg[i] <= 1'b0;
        cbc_cnt_reg[i] <= '0;
      end else if (ce_in) begin
        if (por_s) begin
          ovl_lat_reg[i] <= 1'b0;
          cbc_cnt_reg[i] <= '0;
        end else begin
          if (cd.overcurrent_trip[i]) begin
            cbc_cnt_reg[i] <= cbc_cnt_reg[i] + 1'b1;
          end else begin
            cbc_cnt_reg[i] <= '0;
          end
          if (latched_oc_mode_in && cd.overcurrent_trip[i]) begin
            ovl_lat_reg[i] <= 1'b1;
          end else if (cd.overcurrent_trip[i] && cbc_cnt_reg[i] >= CW'(CBC_LIMIT_CYC - 1)) begin
            ovl_lat_reg[i] <= 1'b1;
          end else if (rstn_rise) begin
            ovl_lat_reg[i] <= 1'b0;
          end
        end
      end
    end

    // Missing PWM: no edge within the window marks the channel idle
    always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
        pwm_d_reg[i] <= 1'b0;
        idle_cnt_reg[i] <= '0;
        pwm_lost_reg[i] <= 1'b1;
      end else if (ce_in) begin
        pwm_d_reg[i] <= pwm_s[i];
        if (pwm_s[i] != pwm_d_reg[i]) begin
          idle_cnt_reg[i] <= '0;
          pwm_lost_reg[i] <= 1'b0;
        end else if (idle_cnt_reg[i] == CW'(PWM_LOSS_CYC - 1)) begin
          pwm_lost_reg[i] <= 1'b1;
        end else begin
          idle_cnt_reg[i] <= idle_cnt_reg[i] + 1'b1;
        end
      end
    end

    assign oc_limiting[i] = cd.overcurrent_trip[i] && !latched_oc_mode_in;
    assign ch_fault[i] = ovl_lat_reg[i] | pwm_lost_reg[i];
  end

  // Map channel faults onto shut-off groups by output configuration
  logic [PFS_NCH-1:0] ch_off;
  always_comb begin
    if (mode_in == PFS_PAR_BRIDGED) begin
      ch_off = {PFS_NCH{|ch_fault}};
    end else begin
      ch_off = {{2{|ch_fault[3:2]}}, {2{|ch_fault[1:0]}}};
    end
  end

  // Global shut-off conditions
  logic glob_off;
  logic all_lost;
  assign all_lost = &pwm_lost_reg;
  assign glob_off = chk_busy | uv_glob | therm_lat_reg | all_lost | !rstn_s;

  // Reported fault: check, supply, thermal latch or overload
  logic fault_rep;
  assign fault_rep = chk_busy | uv_glob | therm_lat_reg | (|ovl_lat_reg);

  // Bridge drive registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hiz_out <= {PFS_NCH{1'b1}};
      hs_on_out <= '0;
      ls_on_out <= '0;
    end else if (ce_in) begin
      for (int k = 0; k < PFS_NCH; k++) begin
        if (glob_off || ch_off[k]) begin
          hiz_out[k] <= 1'b1;
          hs_on_out[k] <= 1'b0;
          ls_on_out[k] <= 1'b0;
        end else begin
          hiz_out[k] <= 1'b0;
          if (oc_limiting[k]) begin
            // Flip state every cycle from flip_reg, ignoring the commanded level, unreported
            hs_on_out[k] <= flip_reg && !cd.bootstrap_cap_low[k];
            ls_on_out[k] <= !flip_reg;
          end else begin
            hs_on_out[k] <= pwm_s[k] && !cd.bootstrap_cap_low[k];
            ls_on_out[k] <= !pwm_s[k];
          end
        end
      end
    end
  end

  // Open-drain fault and warning pins; enable high pulls the pin low
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_oe_out <= 1'b0;
      fault_o_out <= 1'b0;
      warn_oe_out <= 1'b0;
      warn_o_out <= 1'b0;
    end else if (ce_in) begin
      fault_o_out <= 1'b0;
      warn_o_out <= 1'b0;
      if (chk_busy) begin
        fault_oe_out <= 1'b1;
      end else if (!rstn_s) begin
        fault_oe_out <= 1'b0;
      end else begin
        fault_oe_out <= fault_rep;
      end
      warn_oe_out <= gd.warn_temp | therm_lat_reg;
    end
  end
endmodule : pfs_supervisor
